// ===== hw/vof_cfg.svh
// Constants of the video output formatter: register subaddresses, field
// positions, write masks, reset values and the counter width.
// Assumes inclusion by bare name from the package and the top module.
`ifndef VOF_CFG_SVH
`define VOF_CFG_SVH

// Register subaddresses
`define VOF_ADDR_GAIN_A        8'h2C
`define VOF_ADDR_GAIN_B        8'h2D
`define VOF_ADDR_POS_LO        8'h2E
`define VOF_ADDR_POS_HI        8'h2F
`define VOF_ADDR_PWDN          8'h30
`define VOF_ADDR_AUX           8'h31
`define VOF_ADDR_RDBK1         8'h32
`define VOF_ADDR_RDBK2         8'h33
`define VOF_ADDR_RDBK3         8'h34
`define VOF_ADDR_OFM           8'h40

// Power-down control fields
`define VOF_FULL_POWER_DOWN_BIT       5
`define VOF_REFERENCE_POWER_DOWN_BIT       3
`define VOF_BANDGAP_POWER_DOWN_BIT      2
`define VOF_PWDN_OSC_BIT       0
`define VOF_PWDN_MASK          8'h2D

// Auxiliary control fields
`define VOF_AUX_CS_SEL_BIT     5
`define VOF_AUX_CS_OFF_BIT     4
`define VOF_AUX_MASK           8'h3F

// Output format control fields
`define VOF_OFM_SRC_BIT        3
`define VOF_OFM_POL_BIT        2
`define VOF_OFM_MASK           8'h0F

// Gain and position masks
`define VOF_GAIN_A_MASK        8'h3F
`define VOF_GAIN_B_MASK        8'h1F
`define VOF_POS_HI_MASK        8'h0F

// Reset values
`define VOF_RST_GAIN_A         8'h20
`define VOF_RST_GAIN_B         8'h10
`define VOF_RST_POS_LO         8'h04
`define VOF_RST_POS_HI         4'h0
`define VOF_RST_CTRL           8'h00

// Pixel counter and divider widths
`define VOF_CNT_W              12

`endif

// ===== hw/vof_pkg.sv
// Types of the video output formatter: format modes and the state record.
// Assumes vof_cfg.svh is on the include path.
`include "vof_cfg.svh"

package vof_pkg;

    // Output format modes, in register code order
    typedef enum logic [1:0]
    {
        VOF_FMT_24,
        VOF_FMT_16,
        VOF_FMT_48I,
        VOF_FMT_48P
    } vof_fmt_e;

    // Whole register state of the formatter
    typedef struct packed {
        logic [7:0]             pwdn;      // Power-down control
        logic [7:0]             aux;       // Auxiliary control
        logic [7:0]             ofm;       // Output format control
        logic [7:0]             gain_a;    // Channel 3 coarse gain
        logic [7:0]             gain_b;    // Channel 3 fine gain
        logic [7:0]             pos_lo;    // Capture position low
        logic [3:0]             pos_hi;    // Capture position high
        logic [7:0]             rdbk1;     // Captured channel 1 sample
        logic [7:0]             rdbk2;     // Captured channel 2 sample
        logic [7:0]             rdbk3;     // Captured channel 3 sample
        logic [23:0]            smp;       // Input stage samples
        logic                   s_hs;      // Input stage line sync
        logic                   hs_prev;   // Previous line sync
        logic [`VOF_CNT_W-1:0]  pix_cnt;   // Next pixel index
        logic [1:0]             act_mode;  // Format in use this line
        logic [`VOF_CNT_W-1:0]  div_cnt;   // Feedback divider count
        logic [23:0]            hold;      // Even pixel of a pair
        logic [23:0]            bus_a;     // Output bus A
        logic [23:0]            bus_b;     // Output bus B
        logic                   oe_a;      // Bus A enable
        logic                   oe_b;      // Bus B enable
        logic                   dclk;      // Output data clock
        logic                   display_line_sync_out;       // Display line sync
        logic                   dls;       // Delayed line sync
        logic                   synth_clk; // Synthesized clock out
        logic                   csync_en;  // Composite sync output on
        logic                   ext_clk;   // External sample clock used
        logic [7:0]             rdata;     // Register read data
    } vof_state_s;

endpackage

// ===== hw/vof_top.sv
// Video output formatter: formats three sample streams onto two buses,
// makes the display line sync, captures one pixel per line for readback
// and holds the power-down and composite sync controls.
// Assumes samples and line sync are synchronous to I_CLK, and that the
// serial control interface decodes subaddress reads and writes onto the
// register port, one access per cycle.
//
// Overview of operation
// RULE1: Capture programmed pixel per line, position resets 0x04
// RULE2: Readback registers hold latest captured sample
// RULE3: Full power-down stops all but control; code floats buses, stops data clock and capture; syncs, synth clock run
// RULE4: Reference power-down disables internal references
// RULE5: Bandgap power-down disables internal bandgap
// RULE6: Software disables oscillator only with external clock
// RULE7: Synth clock still driven with external clock
// RULE8: Composite sync source: channel 1 or input
// RULE9: Composite sync output enabled when bit zero
// RULE10: Software leaves test bits at zero
// RULE11: Source 1: line sync delayed by pipeline
// RULE12: Source 0: pulse per feedback divider count
// RULE13: Divider pulses last one clock cycle
// RULE14: Divider pulses come without line sync
// RULE15: Polarity bit: 0 high, 1 low
// RULE16: Code 00: 24 bits bus A
// RULE17: Code 01: 16-bit 4:2:2 on bus A
// RULE18: Code 10: 48 bits, bus B offset
// RULE19: Code 11: 48 bits, buses together
// RULE20: Earlier pixel on bus A, later B
// RULE21: Delayed line sync marks chroma order
// RULE22: Clock source select: 0 internal, 1 external
// RULE23: Pixel counter restarts at line sync edge
// RULE24: Format changes apply at line boundary
`timescale 1ns/100ps
`default_nettype none
`include "vof_cfg.svh"

module vof_top
    import vof_pkg::*;
(
    input  wire logic                  I_CLK,                 // Sampling clock
    input  wire logic                  I_RST_N,               // Async reset
    input  wire logic [7:0]            I_CH1_DATA,            // Channel 1 sample
    input  wire logic [7:0]            I_CH2_DATA,            // Channel 2 sample
    input  wire logic [7:0]            I_CH3_DATA,            // Channel 3 sample
    input  wire logic                  I_LINE_SYNC_IN,        // Line sync, active high
    input  wire logic [`VOF_CNT_W-1:0] I_FEEDBACK_DIVIDER_COUNT, // Divider length
    input  wire logic                  I_SAMPLE_CLOCK_SOURCE, // Clock source select
    input  wire logic [7:0]            I_REG_ADDR,            // Subaddress
    input  wire logic [7:0]            I_REG_WDATA,           // Write data
    input  wire logic                  I_REG_WR,              // Write strobe
    input  wire logic                  I_REG_RD,              // Read strobe
    output logic      [7:0]            O_REG_RDATA,           // Read data
    output logic      [23:0]           O_BUS_A,               // Output bus A
    output logic                       O_BUS_A_OE,            // Bus A driven
    output logic      [23:0]           O_BUS_B,               // Output bus B
    output logic                       O_BUS_B_OE,            // Bus B driven
    output logic                       O_OUTPUT_DATA_CLOCK,   // Data clock phase
    output logic                       O_DISPLAY_LINE_SYNC_OUT, // Display sync
    output logic                       O_DELAYED_LINE_SYNC,   // Delayed line sync
    output logic                       O_SYNTH_CLOCK_OUT,     // Synthesized clock
    output logic                       O_USE_EXT_SAMPLE_CLOCK, // Clock mux select
    output logic                       O_FULL_POWER_DOWN,     // Whole device off
    output logic                       O_REFERENCE_POWER_DOWN, // References off
    output logic                       O_BANDGAP_POWER_DOWN,  // Bandgap off
    output logic                       O_OSCILLATOR_DISABLE,  // Oscillator off
    output logic                       O_COMP_SYNC_SRC_INPUT, // Slicer source
    output logic                       O_COMP_SYNC_OUT_EN     // Sync output on
);

    // Reset synchroniser and released reset
    logic [1:0]            rst_sync_r;  // Two-stage release
    logic                  rst_n;       // Synchronised reset

    // State and its next value
    vof_state_s            st_r;        // Registered state
    vof_state_s            st_nxt;      // Next state

    // Values worked out in the combinational process
    logic                  line_edge;   // Active line sync edge
    logic [`VOF_CNT_W-1:0] cur_idx;     // Index of stage pixel
    logic                  cap_hit;     // Stage pixel is captured
    logic                  div_hit;     // Divider reaches its end
    logic [`VOF_CNT_W-1:0] div_top;     // Last divider count
    vof_fmt_e              mode_now;    // Format for stage pixel
    logic                  phase;       // Odd pixel of a pair
    logic                  pd;          // Full power-down

    // Reset values of the state
    localparam vof_state_s ST_RST = '{
        pwdn:     `VOF_RST_CTRL,
        aux:      `VOF_RST_CTRL,
        ofm:      `VOF_RST_CTRL,
        gain_a:   `VOF_RST_GAIN_A,
        gain_b:   `VOF_RST_GAIN_B,
        pos_lo:   `VOF_RST_POS_LO,
        pos_hi:   `VOF_RST_POS_HI,
        csync_en: 1'b1,
        default:  '0
    };

    // Position write value masked to the field
    function automatic logic [3:0] pos_hi_field(input logic [7:0] d);
        logic [7:0] m;
        m = d & `VOF_POS_HI_MASK;
        return m[3:0];
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // Next-state logic of the whole block
    always_comb
    begin
        st_nxt    = st_r;
        pd        = st_r.pwdn[`VOF_FULL_POWER_DOWN_BIT];
        // Pixel counter restarts on the rising line sync
        line_edge = st_r.s_hs & ~st_r.hs_prev; // RULE23
        cur_idx   = line_edge ? '0 : st_r.pix_cnt; // RULE23
        phase     = cur_idx[0];
        cap_hit   = (cur_idx == {st_r.pos_hi, st_r.pos_lo}) & ~pd; // RULE1
        // New format only at the start of a line
        mode_now  = line_edge ? vof_fmt_e'(st_r.ofm[1:0]) : vof_fmt_e'(st_r.act_mode); // RULE24
        st_nxt.act_mode = mode_now; // RULE24

        // Input stage
        st_nxt.smp     = {I_CH1_DATA, I_CH2_DATA, I_CH3_DATA};
        st_nxt.s_hs    = I_LINE_SYNC_IN;
        st_nxt.hs_prev = st_r.s_hs;
        // Counter saturates on overlong lines
        if (cur_idx == '1)
        begin
            st_nxt.pix_cnt = cur_idx;
        end
        else
        begin
            st_nxt.pix_cnt = cur_idx + 12'h001; // RULE23
        end

        // Per-line capture for readback
        if (cap_hit)
        begin
            st_nxt.rdbk1 = st_r.smp[23:16]; // RULE2
            st_nxt.rdbk2 = st_r.smp[15:8]; // RULE2
            st_nxt.rdbk3 = st_r.smp[7:0]; // RULE2
        end

        // Feedback divider, free running regardless of line sync
        div_top = (I_FEEDBACK_DIVIDER_COUNT == '0) ? '0 : I_FEEDBACK_DIVIDER_COUNT - 12'h001;
        div_hit = (st_r.div_cnt >= div_top); // RULE14
        st_nxt.div_cnt = div_hit ? '0 : st_r.div_cnt + 12'h001; // RULE12

        // Display sync source and polarity
        if (st_r.ofm[`VOF_OFM_SRC_BIT])
        begin
            st_nxt.display_line_sync_out = st_r.s_hs ^ st_r.ofm[`VOF_OFM_POL_BIT]; // RULE11 RULE15
        end
        else
        begin
            st_nxt.display_line_sync_out = div_hit ^ st_r.ofm[`VOF_OFM_POL_BIT]; // RULE12 RULE13 RULE15
        end
        st_nxt.dls = st_r.s_hs; // RULE21

        // Synthesized clock runs while the oscillator is on
        st_nxt.synth_clk = st_r.pwdn[`VOF_PWDN_OSC_BIT] ? 1'b0 : ~st_r.synth_clk; // RULE7
        st_nxt.ext_clk   = I_SAMPLE_CLOCK_SOURCE; // RULE22
        st_nxt.csync_en  = ~st_r.aux[`VOF_AUX_CS_OFF_BIT]; // RULE9

        // Bus enables; full power-down floats both buses
        st_nxt.oe_a = ~pd; // RULE3
        st_nxt.oe_b = ~pd & mode_now[1]; // RULE16 RULE17
        if (~phase)
        begin
            st_nxt.hold = st_r.smp;
        end

        // Output formatter
        unique case (mode_now)
            VOF_FMT_24:
            begin
                // Whole pixel each cycle
                st_nxt.bus_a = st_r.smp; // RULE16
                st_nxt.dclk  = 1'b1; // RULE16
            end
            VOF_FMT_16:
            begin
                // Luma every pixel, chroma 4:2:2 alternating
                if (~phase)
                begin
                    st_nxt.bus_a = {st_r.smp[23:8], 8'h00}; // RULE17
                end
                else
                begin
                    st_nxt.bus_a = {st_r.smp[23:16], st_r.hold[7:0], 8'h00}; // RULE17
                end
                st_nxt.dclk = 1'b1; // RULE17
            end
            VOF_FMT_48I:
            begin
                // Even pixel to A, odd to B one clock later
                if (~phase)
                begin
                    st_nxt.bus_a = st_r.smp; // RULE18 RULE20
                end
                else
                begin
                    st_nxt.bus_b = st_r.smp; // RULE18 RULE20
                end
                st_nxt.dclk = ~phase; // RULE18
            end
            VOF_FMT_48P:
            begin
                // Both pixels of a pair together
                if (phase)
                begin
                    st_nxt.bus_a = st_r.hold; // RULE19 RULE20
                    st_nxt.bus_b = st_r.smp; // RULE19 RULE20
                end
                st_nxt.dclk = phase; // RULE19
            end
        endcase
        if (pd)
        begin
            st_nxt.dclk = 1'b0; // RULE3
        end

        // Register writes; readback registers ignore writes
        if (I_REG_WR)
        begin
            unique case (I_REG_ADDR)
                `VOF_ADDR_GAIN_A: st_nxt.gain_a = I_REG_WDATA & `VOF_GAIN_A_MASK;
                `VOF_ADDR_GAIN_B: st_nxt.gain_b = I_REG_WDATA & `VOF_GAIN_B_MASK;
                `VOF_ADDR_POS_LO: st_nxt.pos_lo = I_REG_WDATA; // RULE1
                `VOF_ADDR_POS_HI: st_nxt.pos_hi = pos_hi_field(I_REG_WDATA); // RULE1
                `VOF_ADDR_PWDN:   st_nxt.pwdn   = I_REG_WDATA & `VOF_PWDN_MASK; // RULE3 RULE4 RULE5
                `VOF_ADDR_AUX:    st_nxt.aux    = I_REG_WDATA & `VOF_AUX_MASK; // RULE8 RULE9
                `VOF_ADDR_OFM:    st_nxt.ofm    = I_REG_WDATA & `VOF_OFM_MASK;
                default:          st_nxt.aux    = st_r.aux;
            endcase
        end

        // Register reads; unmapped subaddresses read zero
        if (I_REG_RD)
        begin
            unique case (I_REG_ADDR)
                `VOF_ADDR_GAIN_A: st_nxt.rdata = st_r.gain_a;
                `VOF_ADDR_GAIN_B: st_nxt.rdata = st_r.gain_b;
                `VOF_ADDR_POS_LO: st_nxt.rdata = st_r.pos_lo;
                `VOF_ADDR_POS_HI: st_nxt.rdata = {4'h0, st_r.pos_hi};
                `VOF_ADDR_PWDN:   st_nxt.rdata = st_r.pwdn;
                `VOF_ADDR_AUX:    st_nxt.rdata = st_r.aux;
                `VOF_ADDR_RDBK1:  st_nxt.rdata = st_r.rdbk1; // RULE2
                `VOF_ADDR_RDBK2:  st_nxt.rdata = st_r.rdbk2; // RULE2
                `VOF_ADDR_RDBK3:  st_nxt.rdata = st_r.rdbk3; // RULE2
                `VOF_ADDR_OFM:    st_nxt.rdata = st_r.ofm;
                default:          st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state
    assign O_REG_RDATA             = st_r.rdata;
    assign O_BUS_A                 = st_r.bus_a;
    assign O_BUS_A_OE              = st_r.oe_a;
    assign O_BUS_B                 = st_r.bus_b;
    assign O_BUS_B_OE              = st_r.oe_b;
    assign O_OUTPUT_DATA_CLOCK     = st_r.dclk;
    assign O_DISPLAY_LINE_SYNC_OUT = st_r.display_line_sync_out;
    assign O_DELAYED_LINE_SYNC     = st_r.dls;
    assign O_SYNTH_CLOCK_OUT       = st_r.synth_clk;
    assign O_USE_EXT_SAMPLE_CLOCK  = st_r.ext_clk;
    assign O_FULL_POWER_DOWN       = st_r.pwdn[`VOF_FULL_POWER_DOWN_BIT];
    assign O_REFERENCE_POWER_DOWN  = st_r.pwdn[`VOF_REFERENCE_POWER_DOWN_BIT];
    assign O_BANDGAP_POWER_DOWN    = st_r.pwdn[`VOF_BANDGAP_POWER_DOWN_BIT];
    assign O_OSCILLATOR_DISABLE    = st_r.pwdn[`VOF_PWDN_OSC_BIT];
    assign O_COMP_SYNC_SRC_INPUT   = st_r.aux[`VOF_AUX_CS_SEL_BIT];
    assign O_COMP_SYNC_OUT_EN      = st_r.csync_en;

    // Checks on the state and outputs
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!rst_n);

    a_rdbk_capture: assert property ( // RULE1
        cap_hit |=> (st_r.rdbk1 == $past(st_r.smp[23:16])) && (st_r.rdbk3 == $past(st_r.smp[7:0])))
        else $error("readback not captured at programmed pixel");

    a_pix_restart: assert property ( // RULE23
        line_edge |=> st_r.pix_cnt == 12'h001)
        else $error("pixel counter did not restart on line sync");

    a_dhs_delayed: assert property ( // RULE11
        ($past(st_r.ofm[`VOF_OFM_SRC_BIT]) && $past(rst_n, 2))
        |-> O_DISPLAY_LINE_SYNC_OUT == ($past(st_r.ofm[`VOF_OFM_POL_BIT]) ^ $past(I_LINE_SYNC_IN, 2)))
        else $error("display sync is not the delayed line sync");

    a_dhs_width: assert property ( // RULE13
        (!st_r.ofm[`VOF_OFM_SRC_BIT] && !st_r.ofm[`VOF_OFM_POL_BIT] && $stable(st_r.ofm)
            && O_DISPLAY_LINE_SYNC_OUT && I_FEEDBACK_DIVIDER_COUNT > 12'h001)
        |=> (!O_DISPLAY_LINE_SYNC_OUT || !$stable(st_r.ofm)))
        else $error("divider sync pulse longer than one cycle");

    a_div_bound: assert property ( // RULE14
        ($stable(I_FEEDBACK_DIVIDER_COUNT) && I_FEEDBACK_DIVIDER_COUNT == 12'h005)
        |-> ##[0:4] div_hit)
        else $error("divider pulse missing");

    a_mode_at_line: assert property ( // RULE24
        !line_edge |=> $stable(st_r.act_mode))
        else $error("format changed inside a line");

    a_bus_b_hiz: assert property ( // RULE16
        $past(!mode_now[1]) |-> !O_BUS_B_OE)
        else $error("bus B driven in a single-bus mode");

    a_pwdn_float: assert property ( // RULE3
        $past(st_r.pwdn[`VOF_FULL_POWER_DOWN_BIT]) |-> (!O_BUS_A_OE && !O_OUTPUT_DATA_CLOCK))
        else $error("outputs active during full power-down");

    a_synth_clk: assert property ( // RULE7
        (!st_r.pwdn[`VOF_PWDN_OSC_BIT] && $past(!st_r.pwdn[`VOF_PWDN_OSC_BIT]))
        |=> O_SYNTH_CLOCK_OUT != $past(O_SYNTH_CLOCK_OUT))
        else $error("synthesized clock stopped while oscillator on");

    a_dclk_half: assert property ( // RULE18
        (mode_now == VOF_FMT_48I && !pd && !line_edge) |=> O_OUTPUT_DATA_CLOCK == !$past(phase))
        else $error("data clock not at half rate in interleaved mode");

endmodule

`default_nettype wire

// ===== tb/vof_display_model.sv
// Display-side model: counts display line sync pulses and active cycles.
// Assumes sync and polarity are synchronous to the sampling clock.
`timescale 1ns/100ps
`default_nettype none
module vof_display_model
(
    input  wire logic        i_clk,    // Sampling clock
    input  wire logic        i_rst_n,  // Reset, active low
    input  wire logic        i_sync,   // Display line sync
    input  wire logic        i_pol,    // 1 when sync is active low
    output logic      [15:0] o_pulses, // Pulse starts seen
    output logic      [15:0] o_cycles  // Active cycles seen
);
    logic act_prev; // Active level one cycle ago
    // Count pulse starts and active cycles; equal counts mean 1-cycle pulses
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            act_prev <= 1'b0;
            o_pulses <= 16'h0000;
            o_cycles <= 16'h0000;
        end
        else
        begin
            act_prev <= i_sync ^ i_pol;
            o_pulses <= o_pulses + 16'((i_sync ^ i_pol) & !act_prev);
            o_cycles <= o_cycles + 16'(i_sync ^ i_pol);
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_video_output_formatter.sv
// Self-checking bench of the video output formatter.
// Assumes vof_top and vof_display_model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "vof_cfg.svh"
module tb_video_output_formatter;
    logic        clk = 1'b0;   // Sampling clock
    logic        rst_n = 1'b0; // Reset, active low
    logic [7:0]  px = 8'h00;   // Free running pixel value
    logic        ls = 1'b0;    // Line sync drive
    logic [11:0] ndiv = 12'h003; // Divider length
    logic        ext = 1'b0;   // External clock select
    logic [7:0]  addr = 8'h00; // Register address
    logic [7:0]  wdata = 8'h00; // Register write data
    logic        wr = 1'b0;    // Write strobe
    logic        rd = 1'b0;    // Read strobe
    logic        pol = 1'b0;   // Polarity as programmed
    logic [1:0]  cur = 2'h0;   // Format of the running line
    logic [7:0]  rdata;        // Outputs of the block
    logic [23:0] bus_a, bus_b;
    logic        oe_a, oe_b, dclk, display_line_sync_out, dls, synth, use_ext;
    logic        pd_all, pd_ref, pd_bg, osc_dis, cs_src, cs_en;
    logic [15:0] pulses, cycles; // Display model counts
    int          num_errors = 0;
    int          n_tests = 0;

    vof_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CH1_DATA(px), .I_CH2_DATA(px ^ 8'h55),
        .I_CH3_DATA(~px), .I_LINE_SYNC_IN(ls), .I_FEEDBACK_DIVIDER_COUNT(ndiv),
        .I_SAMPLE_CLOCK_SOURCE(ext), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
        .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_BUS_A(bus_a), .O_BUS_A_OE(oe_a), .O_BUS_B(bus_b),
        .O_BUS_B_OE(oe_b), .O_OUTPUT_DATA_CLOCK(dclk), .O_DISPLAY_LINE_SYNC_OUT(display_line_sync_out),
        .O_DELAYED_LINE_SYNC(dls), .O_SYNTH_CLOCK_OUT(synth), .O_USE_EXT_SAMPLE_CLOCK(use_ext),
        .O_FULL_POWER_DOWN(pd_all), .O_REFERENCE_POWER_DOWN(pd_ref), .O_BANDGAP_POWER_DOWN(pd_bg),
        .O_OSCILLATOR_DISABLE(osc_dis), .O_COMP_SYNC_SRC_INPUT(cs_src), .O_COMP_SYNC_OUT_EN(cs_en));
    vof_display_model u_disp (.i_clk(clk), .i_rst_n(rst_n), .i_sync(display_line_sync_out), .i_pol(pol),
        .o_pulses(pulses), .o_cycles(cycles));

    // Clock, 100 ns period
    initial
    begin
        forever #50 clk = ~clk;
    end
    // New sample value every cycle
    always @(posedge clk) px <= px + 8'h01;
    // Three channel word of one pixel value
    function automatic logic [23:0] pixw(input logic [7:0] x);
        return {x, x ^ 8'h55, ~x};
    endfunction
    // Compare and count
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register write, taken at the second edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // Register read, data valid from the edge that takes it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // Line sync of w cycles; p0 is the pixel 0 sample, read at its first high edge
    task automatic line(input int w, output logic [7:0] p0);
        @(posedge clk);
        ls <= 1'b1;
        @(posedge clk);
        p0 = px;
        repeat (w - 1) @(posedge clk);
        ls <= 1'b0;
    endtask
    // Reset values and an unmapped read
    task automatic t_reset();
        rd_chk(`VOF_ADDR_POS_LO, 8'h04);
        rd_chk(`VOF_ADDR_POS_HI, 8'h00);
        rd_chk(`VOF_ADDR_GAIN_A, 8'h20);
        rd_chk(`VOF_ADDR_GAIN_B, 8'h10);
        rd_chk(`VOF_ADDR_PWDN, 8'h00);
        rd_chk(`VOF_ADDR_OFM, 8'h00);
        rd_chk(8'h50, 8'h00);
        chk({cs_en, pd_all, oe_a}, 3'h5);
    endtask
    // Clock select, power-down bits and composite sync controls
    task automatic t_power();
        logic s;
        @(posedge clk);
        ext <= 1'b1;
        repeat (3) @(negedge clk);
        s = synth;
        @(negedge clk);
        chk({use_ext, synth}, {1'b1, ~s});
        reg_wr(`VOF_ADDR_PWDN, 8'hFF);
        rd_chk(`VOF_ADDR_PWDN, 8'h2D);
        chk({pd_all, pd_ref, pd_bg, osc_dis, oe_a, dclk, synth}, 7'h78);
        reg_wr(`VOF_ADDR_PWDN, 8'h00);
        reg_wr(`VOF_ADDR_AUX, 8'h30);
        rd_chk(`VOF_ADDR_AUX, 8'h30);
        chk({cs_src, cs_en}, 2'h2);
        reg_wr(`VOF_ADDR_AUX, 8'h00);
        @(posedge clk);
        ext <= 1'b0;
        repeat (3) @(negedge clk);
        chk({use_ext, pd_all, oe_a, cs_src, cs_en}, 5'h05);
    endtask
    // Capture of a programmed pixel, read-only readback
    task automatic t_capture();
        logic [7:0]  p0;
        logic [7:0]  c;
        logic [23:0] w;
        reg_wr(`VOF_ADDR_POS_LO, 8'h07);
        line(1, p0);
        c = p0 + 8'h07;
        w = pixw(c);
        repeat (20) @(posedge clk);
        rd_chk(`VOF_ADDR_RDBK1, w[23:16]);
        rd_chk(`VOF_ADDR_RDBK2, w[15:8]);
        rd_chk(`VOF_ADDR_RDBK3, w[7:0]);
        reg_wr(`VOF_ADDR_RDBK1, 8'hEE);
        rd_chk(`VOF_ADDR_RDBK1, w[23:16]);
    endtask
    // One output format on a fresh line
    task automatic t_fmt(input logic [1:0] code);
        logic [7:0]  p0;
        logic [23:0] a2;
        logic        d2;
        reg_wr(`VOF_ADDR_OFM, {6'h00, code});
        repeat (2) @(negedge clk);
        chk(oe_b, cur[1]);
        line(1, p0);
        cur = code;
        @(posedge clk);
        @(negedge clk);
        a2 = bus_a;
        d2 = dls;
        @(negedge clk);
        chk({d2, oe_b, dclk}, {1'b1, code[1], code != 2'h2});
        case (code)
            2'h0: chk({a2, bus_a}, {pixw(p0), pixw(p0 + 8'h01)});
            2'h1: chk({a2, bus_a}, {p0, p0 ^ 8'h55, 8'h00, p0 + 8'h01, ~p0, 8'h00});
            2'h2: chk({a2, bus_a, bus_b}, {pixw(p0), pixw(p0), pixw(p0 + 8'h01)});
            default: chk({bus_a, bus_b}, {pixw(p0), pixw(p0 + 8'h01)});
        endcase
    endtask
    // Display sync from the delayed line sync, active low
    task automatic t_sync();
        logic [7:0] p0;
        int         n1;
        int         n2;
        reg_wr(`VOF_ADDR_OFM, 8'h0C);
        pol = 1'b1;
        n1 = 0;
        n2 = 0;
        // Let the new source settle, then watch the whole pulse
        @(posedge clk);
        fork
            line(3, p0);
            repeat (10)
            begin
                @(negedge clk);
                n1 += !display_line_sync_out;
                n2 += dls;
            end
        join
        chk({n1[3:0], n2[3:0]}, 8'h33);
    endtask
    // Divider-sourced display sync with no line sync present
    task automatic t_div();
        logic [15:0] p;
        logic [15:0] c;
        @(posedge clk);
        ndiv <= 12'h005;
        reg_wr(`VOF_ADDR_OFM, 8'h00);
        pol = 1'b0;
        repeat (10) @(negedge clk);
        p = pulses;
        c = cycles;
        repeat (40) @(negedge clk);
        chk({pulses - p, cycles - c}, 32'h0008_0008);
    endtask
    // Verdict and end of run
    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_power();
        t_capture();
        for (int k = 0; k < 5; k++)
            t_fmt(2'(k));
        t_sync();
        t_div();
        tally_and_finish();
    end
    // Watchdog, far beyond the expected few hundred cycles
    initial
    begin
        #500000;
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
